/* verilog/tfp_consts.svh */
`ifndef TFP_CONSTS_SVH
`define TFP_CONSTS_SVH

// ==========================================================
// Sizes
`define TFP_TX_FIFO_DEPTH 4
`define TFP_TX_LANE_BITS 11
`define TFP_RX_LANE_BITS 13

// ==========================================================
// Code-group fields and values
`define TFP_K28 5'h1C
`define TFP_K28_6B 6'h0F
`define TFP_COMMA_NEG 7'h1F
`define TFP_COMMA_POS 7'h60
`define TFP_K28_5_NEG 10'h0FA
`define TFP_D0_6B_NEG 6'h27
// Idle lane {force value, force mode, k, data}: K28.5
`define TFP_IDLE_LANE 11'h1BC

`endif

/* verilog/tfp_pkg.sv */
package tfp_pkg;
    // Fabric word width: one, two or four characters
    typedef enum logic [1:0] {
        TFP_W1 = 2'h0,
        TFP_W2 = 2'h1,
        TFP_W4 = 2'h3
    } tfp_width_t;

    // Comma polarity selection
    typedef enum logic [1:0] {
        TFP_POL_BOTH = 2'h0,
        TFP_POL_POS = 2'h1,
        TFP_POL_NEG = 2'h3
    } tfp_comma_pol_t;
endpackage : tfp_pkg

/* verilog/tfp_fifo.sv */
`timescale 1ns/1ps
module tfp_fifo #(
    parameter int WIDTH = 44,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ==========================================================
    // Elaboration check: pointers wrap only on a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("tfp_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] cnt_ff;
    logic full_ff;
    logic empty_ff;
    logic [AW:0] nxt_cnt;
    wire wr_fire = wr_valid && !full_ff;
    wire rd_fire = rd_ready && !empty_ff;

    // Flags are flops so the ready seen outside is glitch free
    assign nxt_cnt = cnt_ff + {{AW{1'b0}}, wr_fire} - {{AW{1'b0}}, rd_fire};
    assign wr_ready = !full_ff;
    assign rd_valid = !empty_ff;
    assign rd_data = mem[rptr_ff];

    // Storage needs no reset; only the pointers and occupancy flops do
    always_ff @(posedge clock) begin
        if (wr_fire) begin
            mem[wptr_ff] <= wr_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
            full_ff <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            wptr_ff <= wptr_ff + AW'(wr_fire);
            rptr_ff <= rptr_ff + AW'(rd_fire);
            cnt_ff <= nxt_cnt;
            full_ff <= (nxt_cnt == (AW+1)'(DEPTH));
            empty_ff <= (nxt_cnt == '0);
        end
    end
endmodule : tfp_fifo

/* verilog/tfp_fabric_path.sv */
`timescale 1ns/1ps
`include "tfp_consts.svh"
module tfp_fabric_path
    import tfp_pkg::*;
#(
    parameter bit MSB_FIRST = 1'b1,
    parameter int TX_FIFO_DEPTH = `TFP_TX_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire tfp_width_t cfg_width,
    input wire logic cfg_tx_fifo_bypass,
    input wire logic cfg_tx_enc_bypass,
    input wire logic cfg_rx_dec_bypass,
    input wire logic cfg_comma_defined_only,
    input wire tfp_comma_pol_t cfg_comma_pol,
    input wire logic tx_word_valid,
    output logic tx_word_ready,
    input wire logic [31:0] tx_char_bits,
    input wire logic [3:0] tx_char_is_k,
    input wire logic [3:0] tx_disparity_force_mode,
    input wire logic [3:0] tx_disparity_force_value,
    output logic tx_running_disparity_out,
    output logic tx_control_code_error,
    output logic tx_fifo_overflow,
    output logic tx_fifo_underflow,
    output logic [9:0] tx_code_group,
    input wire logic rx_code_valid,
    input wire logic [9:0] rx_code_group,
    output logic rx_word_valid,
    output logic [31:0] rx_char_bits,
    output logic [3:0] rx_control_char_flag,
    output logic [3:0] rx_disparity_error,
    output logic [3:0] rx_out_of_table_error,
    output logic [3:0] rx_running_disparity_out,
    output logic [3:0] rx_comma_detect
);
    localparam int TLB = `TFP_TX_LANE_BITS;
    localparam int RLB = `TFP_RX_LANE_BITS;

    if (TX_FIFO_DEPTH < 2) begin : g_bad_depth
        $error("tfp_fabric_path: TX_FIFO_DEPTH below 2");
    end

    // ==========================================================
    // Code tables, negative-disparity forms
    localparam logic [5:0] TAB6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] TAB4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    // Positive-disparity twin of a 6-bit sub-block
    function automatic logic [5:0] twin6(input logic [5:0] c);
        if (c == 6'h38) return 6'h07;
        return ($countones(c) != 3) ? ~c : c;
    endfunction : twin6

    // Positive-disparity twin of a 4-bit sub-block
    function automatic logic [3:0] twin4(input logic [3:0] c);
        if (c == 4'hC) return 4'h3;
        return ($countones(c) != 2) ? ~c : c;
    endfunction : twin4

    // Encode: returns {k error, rd after, code group}
    function automatic logic [11:0] enc(input logic k,
        input logic [7:0] d, input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic k28;
        logic kok;
        logic alt;
        logic rdm;
        logic [5:0] s6;
        logic [3:0] s4;
        x = d[4:0];
        y = d[7:5];
        k28 = k && (x == `TFP_K28);
        kok = (x == `TFP_K28) || (y == 3'h7 && (x == 5'h17 ||
            x == 5'h1B || x == 5'h1D || x == 5'h1E));
        s6 = k28 ? `TFP_K28_6B : TAB6[x];
        rdm = ($countones(s6) == 3) ? rd : !rd;
        if (rd) begin
            s6 = twin6(s6);
        end
        alt = (y == 3'h7) && (k || (!rdm && (x == 5'h11 ||
            x == 5'h12 || x == 5'h14)) || (rdm && (x == 5'h0B ||
            x == 5'h0D || x == 5'h0E)));
        s4 = alt ? 4'h7 : TAB4[y];
        if (s4 == 4'hC || $countones(s4) != 2) begin
            s4 = rdm ? twin4(s4) : s4;
        end else if (k28 && !rdm) begin
            s4 = ~s4; // Balanced K28 tails flip under negative rd
        end
        return {k && !kok, ($countones(s4) == 2) ? rdm : !rdm, s6, s4};
    endfunction : enc

    // Decode: returns {k, disp err, oot err, rd after, data}
    function automatic logic [11:0] dec(input logic [9:0] c,
        input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [4:0] x;
        logic [2:0] y;
        logic f6;
        logic f4;
        logic a7;
        logic k28;
        logic rdm;
        logic derr;
        logic oot;
        logic kk;
        int n6;
        int n4;
        s6 = c[9:4];
        s4 = c[3:0];
        x = '0;
        y = '0;
        f6 = 1'b0;
        f4 = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (s6 == TAB6[i] || s6 == twin6(TAB6[i])) begin
                f6 = 1'b1;
                x = 5'(i);
            end
        end
        k28 = (s6 == `TFP_K28_6B) || (s6 == ~`TFP_K28_6B);
        if (k28) begin
            f6 = 1'b1;
            x = `TFP_K28;
        end
        n6 = $countones(s6);
        n4 = $countones(s4);
        rdm = (n6 == 3) ? rd : (n6 > 3);
        if (k28 && !rdm && n4 == 2 && s4 != 4'hC && s4 != 4'h3) begin
            s4 = ~s4;
        end
        for (int j = 0; j < 8; j++) begin
            if (s4 == TAB4[j] || s4 == twin4(TAB4[j])) begin
                f4 = 1'b1;
                y = 3'(j);
            end
        end
        a7 = (s4 == 4'h7) || (s4 == 4'h8);
        if (a7) begin
            f4 = 1'b1;
            y = 3'h7;
        end
        kk = k28 || (a7 && (x == 5'h17 || x == 5'h1B ||
            x == 5'h1D || x == 5'h1E));
        oot = !f6 || !f4 || (a7 && !kk && !(x == 5'h11 ||
            x == 5'h12 || x == 5'h14 || x == 5'h0B || x == 5'h0D ||
            x == 5'h0E));
        derr = (rd && (n6 > 3 || s6 == 6'h38)) ||
            (!rd && (n6 < 3 || s6 == 6'h07)) ||
            (rdm && (n4 > 2 || s4 == 4'hC)) ||
            (!rdm && (n4 < 2 || s4 == 4'h3));
        return {kk, derr && !oot, oot,
            (n4 == 2) ? rdm : (n4 > 2), y, x};
    endfunction : dec

    // ==========================================================
    // Word stride shared by both directions
    logic [1:0] lanes_m1;
    assign lanes_m1 = (cfg_width == TFP_W1) ? 2'h0 :
        (cfg_width == TFP_W2) ? 2'h1 : 2'h3;

    // ==========================================================
    // Transmit: pack, buffer, serialise, encode
    logic [4*TLB-1:0] tx_pack;
    logic [4*TLB-1:0] fifo_rd_data;
    logic [4*TLB-1:0] tx_word_ff;
    logic [TLB-1:0] tx_lane [4];
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic byp_rdy_ff;
    logic [1:0] tx_lane_ff;
    logic tx_rd_ff;
    logic [9:0] tx_code_ff;
    logic kerr_ff;
    logic ovf_ff;
    logic unf_ff;

    // Lane layout {force value, force mode, k, data}
    for (genvar i = 0; i < 4; i++) begin : g_tx_lane
        assign tx_pack[i*TLB +: TLB] = {tx_disparity_force_value[i],
            tx_disparity_force_mode[i], tx_char_is_k[i],
            tx_char_bits[i*8 +: 8]};
        assign tx_lane[i] = tx_word_ff[i*TLB +: TLB];
    end

    wire tx_last = (tx_lane_ff == lanes_m1);
    wire [1:0] tx_nxt_lane = tx_last ? 2'h0 : tx_lane_ff + 2'h1;
    wire src_valid = cfg_tx_fifo_bypass ? tx_word_valid : fifo_rd_valid;
    wire [4*TLB-1:0] src_data = cfg_tx_fifo_bypass ? tx_pack :
        fifo_rd_data;
    wire [1:0] tx_idx = MSB_FIRST ? lanes_m1 - tx_lane_ff :
        tx_lane_ff;
    wire [TLB-1:0] cur = tx_lane[tx_idx];
    wire cur_val = cur[10];
    wire cur_mode = cur[9];
    wire [11:0] enc_out = enc(cur[8], cur[7:0],
        cur_mode ? cur_val : tx_rd_ff);

    // Bypass ready is a flop; the FIFO's own ready is one as well
    assign tx_word_ready = cfg_tx_fifo_bypass ? byp_rdy_ff :
        fifo_wr_ready;

    tfp_fifo #(
        .WIDTH(4*TLB),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .nrst(nrst),
        .wr_valid(tx_word_valid && !cfg_tx_fifo_bypass),
        .wr_data(tx_pack),
        .wr_ready(fifo_wr_ready),
        .rd_valid(fifo_rd_valid),
        .rd_data(fifo_rd_data),
        .rd_ready(tx_last && !cfg_tx_fifo_bypass)
    );

    // Word fetch and error pulses; a starved line sends idle commas unless the encoder is bypassed
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_lane_ff <= 2'h0;
            byp_rdy_ff <= 1'b0;
            tx_word_ff <= {4{`TFP_IDLE_LANE}};
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
        end else begin
            tx_lane_ff <= tx_nxt_lane;
            byp_rdy_ff <= (tx_nxt_lane == lanes_m1);
            if (tx_last) begin
                tx_word_ff <= src_valid ? src_data :
                    {4{`TFP_IDLE_LANE}};
            end
            ovf_ff <= !cfg_tx_fifo_bypass && tx_word_valid &&
                !fifo_wr_ready;
            unf_ff <= tx_last && !src_valid;
        end
    end

    // Encoder state; bypass keeps the disparity where it was
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_rd_ff <= 1'b0;
            tx_code_ff <= 10'h000;
            kerr_ff <= 1'b0;
        end else begin
            tx_code_ff <= cfg_tx_enc_bypass ?
                {cur_mode, cur_val, cur[7:0]} : enc_out[9:0];
            tx_rd_ff <= cfg_tx_enc_bypass ? tx_rd_ff : enc_out[10];
            kerr_ff <= !cfg_tx_enc_bypass && enc_out[11];
        end
    end

    assign tx_code_group = tx_code_ff;
    assign tx_running_disparity_out = tx_rd_ff;
    assign tx_control_code_error = kerr_ff;
    assign tx_fifo_overflow = ovf_ff;
    assign tx_fifo_underflow = unf_ff;

    // ==========================================================
    // Receive: decode, comma detect, gather lanes into words
    logic [1:0] rx_lane_ff;
    logic rx_rd_ff;
    logic rx_vld_ff;
    logic [RLB-1:0] rx_acc_ff [4];
    logic [RLB-1:0] rx_out_ff [4];
    logic [RLB-1:0] nxt_acc [4];

    wire [11:0] dec_out = dec(rx_code_group, rx_rd_ff);
    wire rx_last = (rx_lane_ff == lanes_m1);
    wire [1:0] rx_slot = MSB_FIRST ? lanes_m1 - rx_lane_ff :
        rx_lane_ff;
    wire c_neg = (rx_code_group[9:3] == `TFP_COMMA_NEG);
    wire c_pos = (rx_code_group[9:3] == `TFP_COMMA_POS);
    wire tail_ok = (rx_code_group[2:0] == 3'h0) ||
        (rx_code_group[2:0] == 3'h1) || (rx_code_group[2:0] == 3'h2);
    wire tail_okp = (rx_code_group[2:0] == 3'h7) ||
        (rx_code_group[2:0] == 3'h6) || (rx_code_group[2:0] == 3'h5);
    wire hit_neg = c_neg && (!cfg_comma_defined_only || tail_ok);
    wire hit_pos = c_pos && (!cfg_comma_defined_only || tail_okp);
    wire comma = (cfg_comma_pol == TFP_POL_POS) ? hit_pos :
        (cfg_comma_pol == TFP_POL_NEG) ? hit_neg :
        (hit_pos || hit_neg);
    wire oot = dec_out[9];
    // Raw bits on bypass or out-of-table; disparity stays computed on out-of-table, on bypass it is code bit 8
    wire [RLB-1:0] rx_field = cfg_rx_dec_bypass ?
        {comma, rx_code_group[8], 2'h0, rx_code_group[9],
        rx_code_group[7:0]} :
        {comma, dec_out[8], oot, dec_out[10],
        oot ? rx_code_group[9] : dec_out[11],
        oot ? rx_code_group[7:0] : dec_out[7:0]};

    // Drop the new lane into its byte slot
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_acc[i] = (2'(i) == rx_slot) ? rx_field : rx_acc_ff[i];
        end
    end

    // Lane counter, disparity and word hand-off
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_lane_ff <= 2'h0;
            rx_rd_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                rx_acc_ff[i] <= '0;
                rx_out_ff[i] <= '0;
            end
        end else begin
            rx_vld_ff <= rx_code_valid && rx_last;
            if (rx_code_valid) begin
                rx_lane_ff <= rx_last ? 2'h0 : rx_lane_ff + 2'h1;
                rx_rd_ff <= dec_out[8];
                for (int i = 0; i < 4; i++) begin
                    rx_acc_ff[i] <= rx_last ? '0 : nxt_acc[i];
                    if (rx_last) begin
                        rx_out_ff[i] <= nxt_acc[i];
                    end
                end
            end
        end
    end

    // Per-lane indicator unpacking
    for (genvar i = 0; i < 4; i++) begin : g_rx_lane
        assign rx_char_bits[i*8 +: 8] = rx_out_ff[i][7:0];
        assign rx_control_char_flag[i] = rx_out_ff[i][8];
        assign rx_disparity_error[i] = rx_out_ff[i][9];
        assign rx_out_of_table_error[i] = rx_out_ff[i][10];
        assign rx_running_disparity_out[i] = rx_out_ff[i][11];
        assign rx_comma_detect[i] = rx_out_ff[i][12];
    end
    assign rx_word_valid = rx_vld_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_word_stride: assert property (tx_last |=> tx_lane_ff == 2'h0)
        else $error("lane counter did not wrap");
    a_byp_order: assert property (cfg_tx_enc_bypass |=>
        tx_code_group == {$past(cur_mode), $past(cur_val),
        $past(cur[7:0])}) else $error("bypass order wrong");
    a_rd_force: assert property (!cfg_tx_enc_bypass && cur_mode &&
        !cur_val && !cur[8] && cur[7:0] == 8'h00 |=>
        tx_code_group[9:4] == `TFP_D0_6B_NEG && !tx_running_disparity_out)
        else $error("forced disparity ignored");
    a_kerr_flag: assert property (!cfg_tx_enc_bypass && cur[8] &&
        cur[4:0] != `TFP_K28 && cur[7:5] != 3'h7 |=>
        tx_control_code_error) else $error("k error missed");
    a_fifo_ovf: assert property (!cfg_tx_fifo_bypass &&
        tx_word_valid && !tx_word_ready |=> tx_fifo_overflow)
        else $error("overflow not reported");
    a_dec_bypass: assert property (rx_code_valid &&
        cfg_rx_dec_bypass && rx_last && rx_slot == 2'h0 |=>
        rx_word_valid && rx_char_bits[7:0] == $past(rx_code_group[7:0])
        && rx_control_char_flag[0] == $past(rx_code_group[9]))
        else $error("decoder bypass mapping wrong");
    a_oot_raw: assert property (rx_code_valid &&
        !cfg_rx_dec_bypass && cfg_width == TFP_W1 && oot |=>
        rx_out_of_table_error[0] && rx_char_bits[7:0] ==
        $past(rx_code_group[7:0])) else $error("illegal group not passed raw");
    a_k28_detect: assert property (rx_code_valid &&
        !cfg_rx_dec_bypass && cfg_width == TFP_W1 && !rx_rd_ff &&
        rx_code_group == `TFP_K28_5_NEG |=> rx_control_char_flag[0] &&
        !rx_out_of_table_error[0] && rx_char_bits[7:0] == 8'hBC &&
        rx_running_disparity_out[0]) else $error("K28.5 missed");
endmodule : tfp_fabric_path

/* verif/tfp_fabric_sink.sv */
`timescale 1ns/1ps
// ==========================================================
// Fabric-side receiver model: counts words that carry a comma in lane 0
module tfp_fabric_sink (
    input wire logic clock,
    input wire logic nrst,
    input wire logic rx_word_valid,
    input wire logic [3:0] rx_comma_detect,
    output int n_commas
);
    // Shares the block clock, so rate and lock hold by construction
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            n_commas <= 0;
        end else if (rx_word_valid && rx_comma_detect[0] === 1'b1) begin
            n_commas <= n_commas + 1;
        end
    end
endmodule : tfp_fabric_sink

/* verif/test_tfp_fabric_path.sv */
`timescale 1ns/1ps
module test_tfp_fabric_path;
    import tfp_pkg::*;
    // ==========================================================
    // Stimulus, loopback and expectations
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ebyp = 1'b0;
    logic fbyp = 1'b0;
    logic cdef = 1'b0;
    logic txv = 1'b0;
    logic rxv = 1'b0;
    logic inj = 1'b0;
    tfp_width_t width = TFP_W1;
    tfp_comma_pol_t pol = TFP_POL_BOTH;
    logic [31:0] txd = 32'h0;
    logic [3:0] txk = 4'h0;
    logic [3:0] txm = 4'h0;
    logic [3:0] txval = 4'h0;
    logic [9:0] injv = 10'h000;
    logic txr, txrd, txerr, ovf, unf, rxwv, s_unf, s_ovf, s_full;
    logic [31:0] rxd;
    logic [3:0] rxk, rxde, rxoot, rxrd, rxcm;
    logic [9:0] txg, rxg;
    int n_errors, comparisons, cycles, n_commas, c0;
    // {k, force value, data, code}: K28.5, D0.0, K28.7 at both disparities
    logic [19:0] tab [6] = '{20'hAF0FA, 20'hEF305, 20'h00274, 20'h4018B,
                             20'hBF0F8, 20'hFF307};
    logic [9:0] w4 [4] = '{10'h2A5, 10'h15A, 10'h3C3, 10'h03C};
    tfp_comma_pol_t pols [3] = '{TFP_POL_BOTH, TFP_POL_POS, TFP_POL_NEG};

    // Serial side looped back unless a group is injected
    assign rxg = inj ? injv : txg;

    tfp_fabric_path #(.MSB_FIRST(1'b1)) tfp_fabric_path_inst (
        .clock(clock), .nrst(nrst), .cfg_width(width),
        .cfg_tx_fifo_bypass(fbyp), .cfg_tx_enc_bypass(ebyp),
        .cfg_rx_dec_bypass(ebyp), .cfg_comma_defined_only(cdef),
        .cfg_comma_pol(pol), .tx_word_valid(txv), .tx_word_ready(txr),
        .tx_char_bits(txd), .tx_char_is_k(txk),
        .tx_disparity_force_mode(txm), .tx_disparity_force_value(txval),
        .tx_running_disparity_out(txrd), .tx_control_code_error(txerr),
        .tx_fifo_overflow(ovf), .tx_fifo_underflow(unf),
        .tx_code_group(txg), .rx_code_valid(rxv), .rx_code_group(rxg),
        .rx_word_valid(rxwv), .rx_char_bits(rxd),
        .rx_control_char_flag(rxk), .rx_disparity_error(rxde),
        .rx_out_of_table_error(rxoot), .rx_running_disparity_out(rxrd),
        .rx_comma_detect(rxcm));

    tfp_fabric_sink tfp_fabric_sink_inst (.clock(clock), .nrst(nrst),
        .rx_word_valid(rxwv), .rx_comma_detect(rxcm), .n_commas(n_commas));

    initial begin
        forever #5 clock = ~clock;
    end

    // Hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask : chk

    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Width and bypass are static, so they change only under reset
    task do_reset(input tfp_width_t w, input logic b, input logic f);
        @(posedge clock);
        nrst <= 1'b0;
        width <= w;
        ebyp <= b;
        fbyp <= f;
        txv <= 1'b0;
        rxv <= 1'b0;
        inj <= 1'b0;
        repeat (10) @(posedge clock);
        chk(txrd, 1'b0);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rxv <= 1'b1;
    endtask : do_reset

    // Offer one word and hold it until the edge that takes it
    task put(input logic [31:0] d, input logic [3:0] k, m, v);
        @(posedge clock);
        txd <= d;
        txk <= k;
        txm <= m;
        txval <= v;
        txv <= 1'b1;
        @(negedge clock);
        for (int i = 0; i < 20 && txr !== 1'b1; i++) @(negedge clock);
        @(posedge clock);
        txv <= 1'b0;
    endtask : put

    task watch(input int n);
        repeat (n) begin
            @(negedge clock);
            s_unf |= unf;
            s_ovf |= ovf;
            s_full |= (txr === 1'b0);
        end
    endtask : watch

    initial begin
        do_reset(TFP_W1, 1'b0, 1'b0);
        {s_unf, s_ovf, s_full} = 3'h0;
        watch(8);
        chk({s_unf, s_ovf}, 2'h2);
        // Idle K28.5 words must raise a comma under every setting
        for (int p = 0; p < 6; p++) begin
            @(posedge clock);
            pol <= pols[p % 3];
            cdef <= p[0];
            watch(4);
            c0 = n_commas;
            watch(8);
            chk(n_commas > c0, 1'b1);
        end
        $display("idle and comma test done");
        for (int i = 0; i < 6; i++) begin
            put({24'h0, tab[i][17:10]}, {3'h0, tab[i][19]}, 4'h1,
                {3'h0, tab[i][18]});
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk(txg, tab[i][9:0]);
            chk(txerr, 1'b0);
            @(negedge clock);
            chk({rxk[0], rxd[7:0]}, {tab[i][19], tab[i][17:10]});
        end
        put(32'h0, 4'h1, 4'h0, 4'h0);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(txerr, 1'b1);
        $display("encoder test done");
        // Groups outside the table come through raw
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            inj <= 1'b1;
            injv <= i ? 10'h3FF : 10'h000;
            @(posedge clock);
            inj <= 1'b0;
            @(negedge clock);
            chk({rxoot[0], rxde[0]}, 2'h2);
            chk({rxk[0], rxd[7:0]}, {injv[9], injv[7:0]});
        end
        // Same comma twice in a row: the second breaks disparity
        @(posedge clock);
        inj <= 1'b1;
        injv <= 10'h0FA;
        repeat (2) @(posedge clock);
        inj <= 1'b0;
        @(negedge clock);
        chk({rxoot[0], rxde[0], rxrd[0]}, 3'h3);
        $display("out of table test done");
        do_reset(TFP_W4, 1'b1, 1'b0);
        put({8'hA5, 8'h5A, 8'hC3, 8'h3C}, 4'h0, 4'hA, 4'h6);
        for (int i = 0; i < 30 && txg !== w4[0]; i++) @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            chk(txg, w4[i]);
            @(negedge clock);
        end
        $display("bypass order test done");
        // Four-byte words pop every fourth cycle, so the FIFO fills
        @(posedge clock);
        txv <= 1'b1;
        {s_unf, s_ovf, s_full} = 3'h0;
        watch(12);
        @(posedge clock);
        txv <= 1'b0;
        s_unf = 1'b0;
        watch(40);
        chk({s_unf, s_ovf, s_full}, 3'h7);
        $display("fifo test done");
        @(posedge clock);
        inj <= 1'b1;
        injv <= w4[0];
        repeat (5) @(posedge clock);
        @(negedge clock);
        for (int i = 0; i < 8 && rxwv !== 1'b1; i++) @(negedge clock);
        chk(rxd, {4{8'hA5}});
        chk({rxk, rxrd, rxde, rxoot}, 16'hF000);
        $display("decoder bypass test done");
        // Two-byte words straight past the FIFO, taken at the last lane
        do_reset(TFP_W2, 1'b1, 1'b1);
        put({8'hA5, 8'h5A, 8'hC3, 8'h3C}, 4'h0, 4'hA, 4'h6);
        for (int i = 0; i < 12 && txg !== w4[2]; i++) @(negedge clock);
        chk(txg, w4[2]);
        @(negedge clock);
        chk(txg, w4[3]);
        $display("fifo bypass test done");
        stop_test();
    end
endmodule : test_tfp_fabric_path
